// >>> design/fa_defs.svh
// Constants of the flash array block: map, fields, geometry, reset values
//
// Overview of operation
// - Erased bit reads zero, programmed bit reads one
// - One 32K array, 52 vector bytes, two protect
// - Rows hold eight pages of eight bytes
// - Smallest erase is one 64-byte row
// - Program writes one latched eight-byte page
// - User array 8000-FDFF, control register at FE0B
// - FFCC-FFFF decode to vector storage
// - Vector high byte even address, priority rises
// - Slots from FFE6 follow fixed timer-to-reset order
// - Rows are 64-byte blocks, row 0 at 8000
// - Internal charge pump makes high voltage
// - Program and erase commanded by control register
// - Security hides array from external viewing
// - Erase and program selects never both set
// - High voltage settable only with program/erase
// - Block size bits select erase extent
// - Divide bits set pump clock divisor 1,2,2,4
`ifndef FA_DEFS_SVH
`define FA_DEFS_SVH

// ==========================================================
// Address map
`define FA_CTRL_ADDR 16'hFE0B
`define FA_PROT1_ADDR 16'hFF80
`define FA_PROT2_ADDR 16'hFF81
`define FA_USER_LO 16'h8000
`define FA_USER_HI 16'hFDFF
`define FA_VEC_LO 16'hFFCC
`define FA_VEC_HI 16'hFFFF

// ==========================================================
// Vector slots (high byte at even address, low byte next)
`define FA_VEC_SECOND_TIMER_OVF 16'hFFE6
`define FA_VEC_SECOND_TIMER_CH1 16'hFFE8
`define FA_VEC_SECOND_TIMER_CH0 16'hFFEA
`define FA_VEC_FIRST_TIMER_OVF 16'hFFEC
`define FA_VEC_FIRST_TIMER_CH3 16'hFFEE
`define FA_VEC_FIRST_TIMER_CH2 16'hFFF0
`define FA_VEC_FIRST_TIMER_CH1 16'hFFF2
`define FA_VEC_FIRST_TIMER_CH0 16'hFFF4
`define FA_VEC_PERIODIC_TIMER 16'hFFF6
`define FA_VEC_CLOCK_SYNTH 16'hFFF8
`define FA_VEC_EXTERNAL_INTERRUPT 16'hFFFA
`define FA_VEC_SOFTWARE_INTERRUPT 16'hFFFC
`define FA_VEC_RESET 16'hFFFE

// ==========================================================
// Control register fields
`define FA_BIT_PROGRAM_SELECT 0
`define FA_BIT_ERASE_SELECT 1
`define FA_BIT_MARGIN 2
`define FA_BIT_HIGH_VOLTAGE_ENABLE 3
`define FA_BIT_BLOCK_SIZE_LOW 4
`define FA_BIT_BLOCK_SIZE_HIGH 5
`define FA_BIT_PUMP_DIVIDE_LOW 6
`define FA_BIT_PUMP_DIVIDE_HIGH 7
`define FA_CTRL_RESET 8'h00

// ==========================================================
// Geometry and erase extents (offsets within the 32K window)
`define FA_PAGE_BYTES 4'h8
`define FA_ROW_PAGES 4'h8
`define FA_ROW_BYTES 16'h0040
`define FA_ROW_LAST 16'h01FF
`define FA_ERASED_BYTE 8'h00
`define FA_MASK_FULL 15'h0000
`define FA_MASK_HALF 15'h4000
`define FA_MASK_EIGHT_ROWS 15'h7E00
`define FA_MASK_ROW 15'h7FC0
`define FA_LAST_FULL 15'h7FFF
`define FA_LAST_HALF 15'h3FFF
`define FA_LAST_EIGHT_ROWS 15'h01FF
`define FA_LAST_ROW 15'h003F
`define FA_READ_ZERO 8'h00

`endif

// >>> design/fa_pkg.sv
// Types shared by the flash array block
package fa_pkg;

  // ==========================================================
  // Operation engine states, one-hot
  typedef enum logic [3:0] {
    FA_IDLE = 4'h1,
    FA_PROG = 4'h2,
    FA_ERASE = 4'h4,
    FA_DONE = 4'h8
  } fa_state_t;

  // ==========================================================
  // Source of the read data in the cycle after a read
  typedef enum logic [1:0] {
    FA_SEL_ZERO = 2'h0,
    FA_SEL_MEM = 2'h1,
    FA_SEL_REG = 2'h2
  } fa_sel_t;

endpackage : fa_pkg

// >>> design/fa_mem_if.sv
// Port bundle between the flash controller and its storage array
`timescale 1ns/100ps
interface fa_mem_if;
  logic [14:0] addr; // Byte offset within the 32K window
  logic [7:0] wdata; // Data to store
  logic we; // Write this cycle
  logic or_mode; // Program: OR data into the cell contents
  logic [7:0] rdata; // Registered read data

  modport ctrl (output addr, output wdata, output we, output or_mode,
                input rdata);
  modport mem (input addr, input wdata, input we, input or_mode,
               output rdata);
endinterface : fa_mem_if

// >>> design/fa_mem.sv
// Storage array for the 32K flash window, registered read data
`timescale 1ns/100ps
module fa_mem (
  input wire logic ref_clk, // Bus clock
  fa_mem_if.mem port // Controller side
);
  import fa_pkg::*;

  logic [7:0] cell_r [32768]; // Cell contents, one byte per offset
  logic [7:0] rdata_r; // Read data register

  // ==========================================================
  // Cells: program sets bits only, erase writes the erased value
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      if (port.or_mode) begin
        cell_r[port.addr] <= cell_r[port.addr] | port.wdata;
      end else begin
        cell_r[port.addr] <= port.wdata;
      end
    end
    rdata_r <= cell_r[port.addr];
  end

  assign port.rdata = rdata_r;

endmodule : fa_mem

// >>> design/fa_top.sv
// Flash array controller: decode, control register, program/erase engine
`timescale 1ns/100ps
`include "fa_defs.svh"
module fa_top (
  input wire logic ref_clk, // Bus clock, 10 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [15:0] bus_addr, // Byte address
  input wire logic [7:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  input wire logic ext_view, // Access comes from an outside viewer
  output logic [7:0] bus_rdata, // Read data, cycle after the strobe
  output logic pump_on, // Charge pump and high voltage on
  output logic pump_tick, // Pump clock enable pulse
  output logic busy // Program or erase engine running
);
  import fa_pkg::*;

  // ==========================================================
  // Helper functions
  // True where an address hits the control register
  function automatic logic is_ctrl(input logic [15:0] a);
    is_ctrl = (a == `FA_CTRL_ADDR);
  endfunction : is_ctrl

  // True in the vector slots, which run to the top of memory; each
  // slot keeps its place in the ordered table as plain storage
  function automatic logic in_vectors(input logic [15:0] a);
    in_vectors = (a >= `FA_VEC_LO);
  endfunction : in_vectors

  // True where an address decodes to array storage
  function automatic logic in_array(input logic [15:0] a);
    in_array = ((a >= `FA_USER_LO) && (a <= `FA_USER_HI))
            || (a == `FA_PROT1_ADDR) || (a == `FA_PROT2_ADDR)
            || in_vectors(a);
  endfunction : in_array

  // Cared address bits for each erase extent
  function automatic logic [14:0] erase_mask(input logic [1:0] bs);
    case (bs)
      2'h0: erase_mask = `FA_MASK_FULL;
      2'h1: erase_mask = `FA_MASK_HALF;
      2'h2: erase_mask = `FA_MASK_EIGHT_ROWS;
      default: erase_mask = `FA_MASK_ROW;
    endcase
  endfunction : erase_mask

  // Last offset within each erase extent
  function automatic logic [14:0] erase_last(input logic [1:0] bs);
    case (bs)
      2'h0: erase_last = `FA_LAST_FULL;
      2'h1: erase_last = `FA_LAST_HALF;
      2'h2: erase_last = `FA_LAST_EIGHT_ROWS;
      default: erase_last = `FA_LAST_ROW;
    endcase
  endfunction : erase_last

  // Erase extent field of a control value
  function automatic logic [1:0] blk_size(input logic [7:0] c);
    blk_size = {c[`FA_BIT_BLOCK_SIZE_HIGH], c[`FA_BIT_BLOCK_SIZE_LOW]};
  endfunction : blk_size

  // Last count of the pump divider: divide by 1, 2, 2 or 4
  function automatic logic [1:0] pump_last(input logic [1:0] fd);
    case (fd)
      2'h0: pump_last = 2'h0;
      2'h3: pump_last = 2'h3;
      default: pump_last = 2'h1;
    endcase
  endfunction : pump_last

  // ==========================================================
  // State
  fa_mem_if mem_bus (); // Link to the storage array

  fa_state_t state_r, state_nxt; // Engine state
  logic [7:0] ctrl_r, ctrl_nxt; // Control register
  logic [7:0] latch_r [8]; // Page data latch
  logic [7:0] latch_nxt [8];
  logic [11:0] page_r, page_nxt; // Latched page (offset bits 14..3)
  logic [14:0] eaddr_r, eaddr_nxt; // Latched erase address
  logic [14:0] base_r, base_nxt; // Erase extent base
  logic [14:0] last_r, last_nxt; // Erase extent last offset
  logic [14:0] idx_r, idx_nxt; // Engine step counter
  fa_sel_t sel_r, sel_nxt; // Read data source
  logic [7:0] regrd_r, regrd_nxt; // Register read data
  logic [1:0] pcnt_r, pcnt_nxt; // Pump divider count
  logic tick_r, tick_nxt; // Pump clock enable
  logic on_r, on_nxt; // Pump on
  logic busy_r, busy_nxt; // Engine running

  logic hv; // High voltage bit as stored
  logic program_select; // Program select as stored
  logic ers; // Erase select as stored
  logic [7:0] wr_ctrl; // Control value after interlocks

  assign hv = ctrl_r[`FA_BIT_HIGH_VOLTAGE_ENABLE];
  assign program_select = ctrl_r[`FA_BIT_PROGRAM_SELECT];
  assign ers = ctrl_r[`FA_BIT_ERASE_SELECT];

  // ==========================================================
  // Storage array
  fa_mem u_mem (
    .ref_clk (ref_clk),
    .port (mem_bus.mem)
  );

  // ==========================================================
  // Control register write value with its interlocks
  always_comb begin
    wr_ctrl = bus_wdata;
    // Both selects asked at once: keep the previous pair
    if (bus_wdata[`FA_BIT_PROGRAM_SELECT]
        && bus_wdata[`FA_BIT_ERASE_SELECT]) begin
      wr_ctrl[`FA_BIT_PROGRAM_SELECT] = program_select;
      wr_ctrl[`FA_BIT_ERASE_SELECT] = ers;
    end
    // High voltage needs program or erase selected
    if (!wr_ctrl[`FA_BIT_PROGRAM_SELECT]
        && !wr_ctrl[`FA_BIT_ERASE_SELECT]) begin
      wr_ctrl[`FA_BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
    end
    // Margin read falls back to zero while high voltage is on
    if (wr_ctrl[`FA_BIT_HIGH_VOLTAGE_ENABLE]) begin
      wr_ctrl[`FA_BIT_MARGIN] = 1'b0;
    end
  end

  // ==========================================================
  // Next-state logic: bus, engine, pump divider
  always_comb begin
    // State holds, read source, pump count and tick default to zero, unless a branch below changes them
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    latch_nxt = latch_r;
    page_nxt = page_r;
    eaddr_nxt = eaddr_r;
    base_nxt = base_r;
    last_nxt = last_r;
    idx_nxt = idx_r;
    sel_nxt = FA_SEL_ZERO;
    regrd_nxt = regrd_r;
    pcnt_nxt = 2'h0;
    tick_nxt = 1'b0;
    // Array port follows the bus address and writes nothing
    mem_bus.addr = bus_addr[14:0];
    mem_bus.wdata = `FA_ERASED_BYTE;
    mem_bus.we = 1'b0;
    mem_bus.or_mode = 1'b0;

    // Control register writes are the only command path
    if (bus_wr && is_ctrl(bus_addr)) begin
      ctrl_nxt = wr_ctrl;
    end

    // Reads: register, array or zero
    if (bus_rd) begin
      if (is_ctrl(bus_addr)) begin
        // Control register reads back as stored
        sel_nxt = FA_SEL_REG;
        regrd_nxt = ctrl_r;
      end else if (in_array(bus_addr) && !ext_view
                   && (state_r == FA_IDLE)) begin
        // Array is hidden from viewers and while the engine runs
        sel_nxt = FA_SEL_MEM;
      end else begin
        // Unmapped, hidden or busy: a plain zero
        sel_nxt = FA_SEL_ZERO;
      end
    end

    // Engine
    case (state_r)
      FA_IDLE: begin
        // Array writes only latch; with no mode they are dropped
        if (bus_wr && in_array(bus_addr) && !hv) begin
          if (program_select) begin
            // Program mode latches the byte into its page slot
            latch_nxt[bus_addr[2:0]] = bus_wdata;
            page_nxt = bus_addr[14:3];
          end else if (ers) begin
            // Erase mode only remembers where the extent lies
            eaddr_nxt = bus_addr[14:0];
          end
        end
        // High voltage starts whichever operation is selected
        if (hv && program_select) begin
          state_nxt = FA_PROG;
          idx_nxt = 15'h0000;
        end else if (hv && ers) begin
          state_nxt = FA_ERASE;
          idx_nxt = 15'h0000;
          // Latched offset keeps only the bits the extent cares about
          base_nxt = eaddr_r & erase_mask(blk_size(ctrl_r));
          last_nxt = erase_last(blk_size(ctrl_r));
        end
      end
      FA_PROG: begin
        // One byte of the page per cycle, bits only set
        mem_bus.addr = {page_r, idx_r[2:0]};
        mem_bus.wdata = latch_r[idx_r[2:0]];
        mem_bus.we = 1'b1;
        mem_bus.or_mode = 1'b1;
        idx_nxt = idx_r + 15'h0001;
        if (idx_r[2:0] == 3'h7) begin
          state_nxt = FA_DONE;
          for (int i = 0; i < 8; i++) begin
            latch_nxt[i] = `FA_ERASED_BYTE;
          end
        end
      end
      FA_ERASE: begin
        // Clear the extent one byte per cycle
        mem_bus.addr = base_r | idx_r;
        mem_bus.wdata = `FA_ERASED_BYTE;
        mem_bus.we = 1'b1;
        idx_nxt = idx_r + 15'h0001;
        if (idx_r == last_r) begin
          state_nxt = FA_DONE;
        end
      end
      FA_DONE: begin
        // One operation per high-voltage pulse
        if (!hv) begin
          state_nxt = FA_IDLE;
        end
      end
      default: begin
        state_nxt = FA_IDLE;
      end
    endcase

    // Pump clock enable while high voltage is on
    // Count wraps at the divisor's last value; the wrap is the tick
    if (hv) begin
      if (pcnt_r >= pump_last({ctrl_r[`FA_BIT_PUMP_DIVIDE_HIGH],
                               ctrl_r[`FA_BIT_PUMP_DIVIDE_LOW]})) begin
        tick_nxt = 1'b1;
        pcnt_nxt = 2'h0;
      end else begin
        pcnt_nxt = pcnt_r + 2'h1;
      end
    end
    // Pump status follows the stored high-voltage bit
    on_nxt = ctrl_nxt[`FA_BIT_HIGH_VOLTAGE_ENABLE];
    // Busy spans the run and the wait for high voltage to drop
    busy_nxt = (state_nxt != FA_IDLE);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Cell contents live in the array and are not reset
      state_r <= FA_IDLE;
      ctrl_r <= `FA_CTRL_RESET;
      for (int i = 0; i < 8; i++) begin
        latch_r[i] <= `FA_ERASED_BYTE;
      end
      page_r <= 12'h000;
      eaddr_r <= 15'h0000;
      base_r <= 15'h0000;
      last_r <= 15'h0000;
      idx_r <= 15'h0000;
      sel_r <= FA_SEL_ZERO;
      regrd_r <= 8'h00;
      pcnt_r <= 2'h0;
      tick_r <= 1'b0;
      on_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      // Every register takes its next value
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      latch_r <= latch_nxt;
      page_r <= page_nxt;
      eaddr_r <= eaddr_nxt;
      base_r <= base_nxt;
      last_r <= last_nxt;
      idx_r <= idx_nxt;
      sel_r <= sel_nxt;
      regrd_r <= regrd_nxt;
      pcnt_r <= pcnt_nxt;
      tick_r <= tick_nxt;
      on_r <= on_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================
  // Outputs; read data picks between two registered sources
  always_comb begin
    // Only one source is live in the cycle after a read
    case (sel_r)
      FA_SEL_MEM: bus_rdata = mem_bus.rdata;
      FA_SEL_REG: bus_rdata = regrd_r;
      default: bus_rdata = `FA_READ_ZERO;
    endcase
  end

  assign pump_on = on_r;
  assign pump_tick = tick_r;
  assign busy = busy_r;

endmodule : fa_top

// >>> verif/fa_top_asserts.sv
// Port checks for the flash array controller
`timescale 1ns/100ps
module fa_top_asserts (
  input wire logic ref_clk, // Bus clock
  input wire logic rst_b, // Reset, low
  input wire logic [15:0] bus_addr, // Address
  input wire logic [7:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  input wire logic ext_view, // Outside viewer
  input wire logic [7:0] bus_rdata, // Read data
  input wire logic pump_on, // Pump on
  input wire logic pump_tick, // Pump pulse
  input wire logic busy // Engine running
);
  logic ctrl_wr; // Control register write
  logic user_rd; // Read of user array
  logic [1:0] div_r; // Shadow of divide bits
  logic [1:0] div_nxt; // Next shadow
  assign ctrl_wr = bus_wr && (bus_addr == 16'hFE0B);
  assign user_rd = bus_rd && bus_addr >= 16'h8000 && bus_addr <= 16'hFDFF;
  // Divide bits follow each control write
  always_comb begin
    div_nxt = ctrl_wr ? bus_wdata[7:6] : div_r;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_nxt;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Assertions
  a_rdata_idle: assert property (
    !$past(bus_rd) |-> bus_rdata == 8'h00) else $error("read data not idle");
  a_view_hidden: assert property (
    $past(user_rd && (ext_view || busy)) |-> bus_rdata == 8'h00)
    else $error("hidden array read leaked");
  a_hv_needs_sel: assert property (
    ctrl_wr && bus_wdata[1:0] == 2'h0 |-> ##[1:2] !pump_on)
    else $error("pump on without select");
  a_tick_quiet: assert property (
    !pump_on && !$past(pump_on) |-> !pump_tick) else $error("tick while off");
  a_tick_div_two: assert property (
    pump_tick && (div_r[0] ^ div_r[1]) |=> !pump_tick)
    else $error("tick spacing not two");
  a_tick_div_four: assert property (
    pump_tick && div_r == 2'h3 |=> !pump_tick [*3])
    else $error("tick spacing not four");
  a_busy_start: assert property (
    ctrl_wr && bus_wdata[3] && (^bus_wdata[1:0]) && !busy |-> ##[1:2] busy)
    else $error("engine did not start");
  a_busy_end: assert property (
    $fell(busy) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("engine stopped without control write");
  a_pump_follows: assert property (
    ctrl_wr && bus_wdata[3] && (^bus_wdata[1:0]) |=> pump_on)
    else $error("pump off after high voltage write");
  a_tick_alive: assert property (
    $rose(pump_on) ##1 pump_on [*3] |-> ##[0:1] pump_tick)
    else $error("no pump tick while high voltage held");
  c_engine: cover property ($rose(busy));
  c_div_four: cover property (pump_tick && div_r == 2'h3);
  c_viewer: cover property ($past(user_rd && ext_view));
endmodule : fa_top_asserts

// >>> verif/fa_cpu_model.sv
// Processor model driving the flash block register bus
`timescale 1ns/100ps
module fa_cpu_model (
  input wire logic ref_clk, // Bus clock
  input wire logic busy, // Engine running
  input wire logic [7:0] bus_rdata, // Read data
  output logic [15:0] bus_addr, // Address
  output logic [7:0] bus_wdata, // Write data
  output logic bus_wr, // Write strobe
  output logic bus_rd // Read strobe
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // One-cycle write; released data shows its inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask : wr
  // One-cycle read; data taken in the cycle after
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask : rd
  // Program one page, then margin read it back
  task automatic prog_page(input logic [15:0] base, input logic [63:0] pg,
                           output logic b);
    logic [7:0] d;
    wr(16'hFE0B, 8'h41);
    for (int i = 0; i < 8; i++) begin
      wr(base + 16'(i), pg[8*i +: 8]);
    end
    wr(16'hFE0B, 8'h49);
    repeat (12) @(posedge ref_clk); // More than the eight page cycles; busy holds in FA_DONE
    @(negedge ref_clk);
    b = busy;
    wr(16'hFE0B, 8'h41);
    wr(16'hFE0B, 8'h45); // Margin read after each pulse
    for (int i = 0; i < 8; i++) begin
      rd(base + 16'(i), d);
    end
    wr(16'hFE0B, 8'h00);
  endtask : prog_page
  // Erase the block holding address a
  task automatic erase_blk(input logic [7:0] c, input logic [15:0] a,
                           input int n, output logic b);
    wr(16'hFE0B, c);
    wr(a, 8'hFF);
    wr(16'hFE0B, c | 8'h08);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
    b = busy;
    wr(16'hFE0B, c);
    wr(16'hFE0B, 8'h00);
  endtask : erase_blk
endmodule : fa_cpu_model

// >>> verif/flash_array_organization_tb_top.sv
// Self-checking bench for the flash array controller
`timescale 1ns/100ps
module flash_array_organization_tb_top;
  logic ref_clk, rst_b, bus_wr, bus_rd, ext_view, pump_on, pump_tick, busy;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, d;
  logic [31:0] seed;
  logic b;
  int fails, checks_done;
  int mdl [int]; // Expected array bytes, absent means erased
  fa_top fa_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .ext_view(ext_view), .bus_rdata(bus_rdata), .pump_on(pump_on),
    .pump_tick(pump_tick), .busy(busy));
  fa_cpu_model fa_cpu_model_i (.ref_clk(ref_clk), .busy(busy),
    .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [15:0] a);
    logic [7:0] want;
    want = mdl.exists(int'(a)) ? 8'(mdl[int'(a)]) : 8'h00;
    fa_cpu_model_i.rd(a, d);
    chk("array byte", d, want);
  endtask : rd_chk
  // Program one random page and read it back
  task automatic prog(input logic [15:0] base);
    logic [63:0] pg;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      pg[8*i +: 8] = seed[7:0];
      mdl[int'(base) + i] = int'(seed[7:0]);
    end
    fa_cpu_model_i.prog_page(base, pg, b);
    chk("busy", {7'h00, b}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rd_chk(base + 16'(i));
    end
  endtask : prog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    ext_view = 1'b0;
    seed = 32'h6503;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    fa_cpu_model_i.rd(16'hFE0B, d);
    chk("control", d, 8'h00);
    fa_cpu_model_i.erase_blk(8'hC2, 16'h9000, 32800, b);
    chk("busy", {7'h00, b}, 8'h01);
    mdl.delete();
    rd_chk(16'h8000);
    rd_chk(16'hFDFF);
    rd_chk(16'hFFCC);
    $display("full erase done");
    fa_cpu_model_i.wr(16'hFE0B, 8'h00);
    fa_cpu_model_i.wr(16'h8000, 8'hA5);
    rd_chk(16'h8000);
    // Each page programmed once between erases
    prog(16'h8008);
    prog(16'h8040);
    prog(16'hFFF8); // Reset vector slot gets a value
    rd_chk(16'hFFFE);
    $display("program done");
    fa_cpu_model_i.erase_blk(8'h72, 16'h8010, 70, b);
    chk("busy", {7'h00, b}, 8'h01);
    for (int i = 32'h8000; i < 32'h8040; i++) mdl.delete(i);
    for (int i = 0; i < 8; i++) begin
      rd_chk(16'h8008 + 16'(i));
      rd_chk(16'h8040 + 16'(i));
    end
    $display("row erase done");
    fa_cpu_model_i.wr(16'hFE0B, 8'h01);
    fa_cpu_model_i.wr(16'hFE0B, 8'h03);
    fa_cpu_model_i.rd(16'hFE0B, d);
    chk("control", d, 8'h01);
    fa_cpu_model_i.wr(16'hFE0B, 8'h08);
    fa_cpu_model_i.rd(16'hFE0B, d);
    chk("control", d, 8'h00);
    @(posedge ref_clk);
    ext_view <= 1'b1;
    fa_cpu_model_i.rd(16'h8040, d);
    chk("viewer read", d, 8'h00);
    @(posedge ref_clk);
    ext_view <= 1'b0;
    fa_cpu_model_i.rd(16'h7FFF, d);
    chk("unmapped", d, 8'h00);
    $display("control and decode done");
    // Upper half array, then the first eight rows at divide by one
    fa_cpu_model_i.erase_blk(8'h52, 16'hC123, 16400, b);
    chk("busy", {7'h00, b}, 8'h01);
    for (int i = 32'hC000; i < 32'h10000; i++) mdl.delete(i);
    rd_chk(16'hFFFE);
    rd_chk(16'h8040);
    fa_cpu_model_i.erase_blk(8'h22, 16'h81C0, 520, b);
    chk("busy", {7'h00, b}, 8'h01);
    for (int i = 32'h8000; i < 32'h8200; i++) mdl.delete(i);
    rd_chk(16'h8041);
    $display("block erase done");
    print_verdict();
  end
endmodule : flash_array_organization_tb_top
bind fa_top fa_top_asserts fa_top_asserts_i (.ref_clk(ref_clk),
  .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .ext_view(ext_view),
  .bus_rdata(bus_rdata), .pump_on(pump_on), .pump_tick(pump_tick),
  .busy(busy));
